/* hw/sensor_readout.sv */
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sensor_readout #(
  parameter int PIX_DIV = readout_pkg::PIX_DIV
) (
  input  wire logic        i_clk_sys,         // master clock, 100 MHz
  input  wire logic        i_nrst,            // synchronous reset, active low
  input  wire logic        i_ref_clk,         // reference clock pin
  input  wire logic        i_fw_active,       // firmware owns the settings
  input  wire logic [7:0]  i_addr,            // register address
  input  wire logic [15:0] i_wr_data,         // register write data
  input  wire logic        i_wr_stb,          // register write strobe
  input  wire logic        i_rd_stb,          // register read strobe
  output logic      [15:0] o_rd_data,         // read data, one cycle later
  input  wire logic [9:0]  i_pix_data,        // sample of the addressed pixel
  output logic      [10:0] o_row_addr,        // row being read
  output logic      [10:0] o_col_addr,        // column being read
  output logic             o_row_read_stb,    // pulse: row read starts
  output logic             o_row_reset_stb,   // pulse: row reset
  output logic      [10:0] o_row_reset_addr,  // row being reset
  output logic             o_pixel_clock_out, // free-running pixel clock
  output logic      [9:0]  o_pix_data,        // pixel word
  output logic      [1:0]  o_pix_color,       // Bayer colour of the word
  output logic             o_line_valid,      // line qualifier
  output logic             o_frame_valid,     // frame qualifier
  output logic             o_ref_ok           // reference in range, pll usable
);

  typedef enum logic [1:0] {ST_IDLE, ST_LINE, ST_HBLANK, ST_VBLANK} rd_state_e;

  // ****************************************************************
  // reference clock check
  // ****************************************************************
  logic       ref_rise;
  logic [7:0] ref_cyc;
  logic [7:0] next_ref_cyc;
  logic [2:0] ref_per;
  logic [2:0] next_ref_per;
  logic [7:0] ref_meas;
  logic [7:0] next_ref_meas;
  logic       next_ref_ok;

  pin_sync u_ref_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_pin     (i_ref_clk),
    .o_level   (),
    .o_rise    (ref_rise)
  );

  // count system cycles over eight reference periods and range-check them
  always_comb begin
    next_ref_cyc  = ref_cyc;
    next_ref_per  = ref_per;
    next_ref_meas = ref_meas;
    next_ref_ok   = o_ref_ok;
    if (ref_cyc == 8'h00) begin
      // count from the first reference edge, so every window spans whole periods
      if (ref_rise) begin
        next_ref_cyc = 8'h01;
      end
    end else if (ref_cyc != 8'hFF) begin
      next_ref_cyc = ref_cyc + 8'h01;
    end else begin
      next_ref_ok   = 1'b0;
      next_ref_meas = 8'hFF;
    end
    if (ref_rise && (ref_cyc != 8'h00)) begin
      next_ref_per = ref_per + 3'h1;
      if (ref_per == 3'(readout_pkg::REF_AVG - 1)) begin
        next_ref_meas = ref_cyc;
        next_ref_cyc  = 8'h01;
        next_ref_ok   = (ref_cyc >= 8'(readout_pkg::REF_CNT_MIN)) &&
                        (ref_cyc <= 8'(readout_pkg::REF_CNT_MAX));
      end
    end
  end

  // register stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ref_cyc  <= 8'h00;
      ref_per  <= 3'h0;
      ref_meas <= 8'h00;
      o_ref_ok <= 1'b0;
    end else begin
      ref_cyc  <= next_ref_cyc;
      ref_per  <= next_ref_per;
      ref_meas <= next_ref_meas;
      o_ref_ok <= next_ref_ok;
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [15:0] hblank;
  logic [15:0] next_hblank;
  logic [15:0] vblank;
  logic [15:0] next_vblank;
  logic [15:0] integ;
  logic [15:0] next_integ;
  logic [15:0] next_rd_data;
  logic [15:0] black_level;
  logic        host_wr;

  assign host_wr = i_wr_stb & ~i_fw_active;

  // host writes land only while firmware is off; reads answer next cycle
  always_comb begin
    next_ctrl    = ctrl;
    next_hblank  = hblank;
    next_vblank  = vblank;
    next_integ   = integ;
    next_rd_data = 16'h0000;
    if (host_wr) begin
      case (i_addr)
        readout_pkg::REG_CTRL:   next_ctrl   = i_wr_data & 16'h000F;
        readout_pkg::REG_HBLANK: next_hblank = i_wr_data;
        readout_pkg::REG_VBLANK: next_vblank = i_wr_data;
        readout_pkg::REG_INTEG:  next_integ  = i_wr_data;
        default:                 next_integ  = integ;
      endcase
    end
    if (i_rd_stb) begin
      case (i_addr)
        readout_pkg::REG_CTRL:   next_rd_data = ctrl;
        readout_pkg::REG_HBLANK: next_rd_data = hblank;
        readout_pkg::REG_VBLANK: next_rd_data = vblank;
        readout_pkg::REG_INTEG:  next_rd_data = integ;
        readout_pkg::REG_STATUS: next_rd_data = {13'h0000, o_line_valid, o_frame_valid,
                                                 o_ref_ok};
        readout_pkg::REG_REFCNT: next_rd_data = {8'h00, ref_meas};
        readout_pkg::REG_ROWPOS: next_rd_data = {5'h00, o_row_addr};
        readout_pkg::REG_BLACK:  next_rd_data = {6'h00, black_level[15:6]};
        default:                 next_rd_data = 16'h0000;
      endcase
    end
  end

  // register stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      ctrl      <= readout_pkg::CTRL_RESET;
      hblank    <= readout_pkg::HBLANK_RESET;
      vblank    <= readout_pkg::VBLANK_RESET;
      integ     <= readout_pkg::INTEG_RESET;
      o_rd_data <= 16'h0000;
    end else begin
      ctrl      <= next_ctrl;
      hblank    <= next_hblank;
      vblank    <= next_vblank;
      integ     <= next_integ;
      o_rd_data <= next_rd_data;
    end
  end

  // ****************************************************************
  // readout sequencer
  // ****************************************************************
  rd_state_e   state;
  rd_state_e   next_state;
  logic [7:0]  div_cnt;
  logic [7:0]  next_div_cnt;
  logic        tick;
  logic        next_pclk;
  logic [10:0] row;
  logic [10:0] next_row;
  logic [10:0] col;
  logic [10:0] next_col;
  logic [16:0] pcnt;
  logic [16:0] next_pcnt;
  logic [15:0] vb_cnt;
  logic [15:0] next_vb_cnt;
  logic        lead;
  logic        next_lead;
  logic [3:0]  live;                      // run, boundary, mirror col, mirror row
  logic [3:0]  next_live;
  logic [15:0] live_hb;
  logic [15:0] next_live_hb;
  logic [15:0] live_vb;
  logic [15:0] next_live_vb;
  logic [15:0] live_integ;
  logic [15:0] next_live_integ;
  logic [10:0] win_w;
  logic [10:0] win_h;
  logic [10:0] row_first;
  logic [10:0] row_last;
  logic [10:0] col_first;
  logic [10:0] col_last;
  logic        last_row;
  logic        cap_valid;
  logic        cap_black;
  logic        fv_cur;
  logic [9:0]  next_pix;
  logic [1:0]  next_color;
  logic        next_lv;
  logic        next_fv;
  logic [15:0] next_black;
  logic [16:0] black_diff;
  logic        next_rd_stb;
  logic        next_rst_stb;
  logic [10:0] next_rst_addr;

  // row reset leads the read row by the exposure, wrapping round the array
  function automatic logic [10:0] reset_row(input logic [10:0] r, input logic [15:0] e);
    logic [16:0] sum;
    sum = {6'h00, r} + {1'b0, e};
    if (sum >= {6'h00, readout_pkg::ARRAY_ROWS}) begin
      sum = sum - {6'h00, readout_pkg::ARRAY_ROWS};
    end
    return (sum >= {6'h00, readout_pkg::ARRAY_ROWS}) ? r : sum[10:0];
  endfunction

  // window geometry from the live settings
  always_comb begin
    win_w     = readout_pkg::WIN_W + (live[1] ? 11'(2 * readout_pkg::BORDER) : 11'h000);
    win_h     = readout_pkg::WIN_H + (live[1] ? 11'(2 * readout_pkg::BORDER) : 11'h000);
    row_first = readout_pkg::WIN_ROW0 - (live[1] ? readout_pkg::BORDER : 11'h000)
                + (live[3] ? readout_pkg::MIRROR_SHIFT : 11'h000);
    col_first = readout_pkg::WIN_COL0 - (live[1] ? readout_pkg::BORDER : 11'h000)
                + (live[2] ? readout_pkg::MIRROR_SHIFT : 11'h000);
    row_last  = row_first + win_h - 11'h001;
    col_last  = col_first + win_w - 11'h001;
    last_row  = !lead && (row == (live[3] ? row_first : row_last));
    cap_valid = (state == ST_LINE) && !lead;
    cap_black = (state == ST_HBLANK) &&
                (pcnt < 17'(readout_pkg::BLACK_LEAD_COLS + readout_pkg::BLACK_TAIL_COLS));
    fv_cur    = !lead && ((state == ST_LINE) || ((state == ST_HBLANK) && !last_row));
  end

  assign tick = (div_cnt == 8'(PIX_DIV - 1));

  // next state of the sequencer and of the pixel outputs
  always_comb begin
    next_div_cnt    = tick ? 8'h00 : div_cnt + 8'h01;
    next_pclk       = (next_div_cnt >= 8'(PIX_DIV / 2));
    next_state      = state;
    next_row        = row;
    next_col        = col;
    next_pcnt       = pcnt;
    next_vb_cnt     = vb_cnt;
    next_lead       = lead;
    next_live       = live;
    next_live_hb    = live_hb;
    next_live_vb    = live_vb;
    next_live_integ = live_integ;
    next_pix        = o_pix_data;
    next_color      = o_pix_color;
    next_lv         = o_line_valid;
    next_fv         = o_frame_valid;
    next_black      = black_level;
    black_diff      = {1'b0, i_pix_data, 6'h00} - {1'b0, black_level};
    next_rd_stb     = 1'b0;
    next_rst_stb    = 1'b0;
    next_rst_addr   = o_row_reset_addr;
    if (tick) begin
      // capture the sample of the address presented over the past period
      next_pix   = cap_valid ? i_pix_data : 10'h000;
      next_lv    = cap_valid;
      next_fv    = fv_cur;
      next_color = {row[0], col[0]};
      if (cap_black) begin
        next_black = black_level + 16'($signed(black_diff) >>> readout_pkg::BLACK_SHIFT);
      end
      case (state)
        ST_IDLE: begin
          if (ctrl[readout_pkg::CTRL_RUN] && o_ref_ok) begin
            next_live       = ctrl[3:0];
            next_live_hb    = hblank;
            next_live_vb    = vblank;
            next_live_integ = integ;
            next_lead       = 1'b1;
            next_row        = readout_pkg::SCAN_ROW0;
            next_col        = readout_pkg::SCAN_COL0;
            next_pcnt       = 17'h00000;
            next_state      = ST_LINE;
          end
        end
        ST_LINE: begin
          next_col  = (live[2] && !lead) ? col - 11'h001 : col + 11'h001;
          next_pcnt = pcnt + 17'h00001;
          if (pcnt == {6'h00, win_w - 11'h001}) begin
            next_pcnt  = 17'h00000;
            next_col   = 11'h000;
            next_state = ST_HBLANK;
          end
        end
        ST_HBLANK: begin
          next_pcnt = pcnt + 17'h00001;
          if (next_pcnt < 17'(readout_pkg::BLACK_LEAD_COLS)) begin
            next_col = next_pcnt[10:0];
          end else if (next_pcnt < 17'(readout_pkg::BLACK_LEAD_COLS +
                                      readout_pkg::BLACK_TAIL_COLS)) begin
            next_col = readout_pkg::ARRAY_COLS - readout_pkg::BLACK_TAIL_COLS
                       + next_pcnt[10:0] - readout_pkg::BLACK_LEAD_COLS;
          end
          // past the shielded columns the column holds, staying inside the array
          if (next_pcnt >= {1'b0, live_hb}) begin
            next_pcnt  = 17'h00000;
            next_state = ST_LINE;
            next_col   = live[2] ? col_last : col_first;
            if (lead) begin
              if (row + 11'h001 >= row_first) begin
                next_lead = 1'b0;
                next_row  = live[3] ? row_last : row_first;
              end else begin
                next_row = row + 11'h001;
                next_col = readout_pkg::SCAN_COL0;
              end
            end else if (last_row) begin
              next_state  = (live_vb == 16'h0000) ? ST_IDLE : ST_VBLANK;
              next_vb_cnt = 16'h0000;
            end else begin
              next_row = live[3] ? row - 11'h001 : row + 11'h001;
            end
          end
        end
        ST_VBLANK: begin
          next_pcnt = pcnt + 17'h00001;
          if (pcnt == {6'h00, win_w} + {1'b0, live_hb} - 17'h00001) begin
            next_pcnt   = 17'h00000;
            next_vb_cnt = vb_cnt + 16'h0001;
            if (vb_cnt == live_vb - 16'h0001) begin
              next_state = ST_IDLE;
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
      // each new row: read it now, reset the row exposure rows below it, read that many rows later unless rows are mirrored
      if ((next_state == ST_LINE) && (state != ST_LINE)) begin
        next_rd_stb   = 1'b1;
        next_rst_stb  = 1'b1;
        next_rst_addr = reset_row(next_row, (state == ST_IDLE) ? integ : live_integ);
      end
    end
  end

  assign o_row_addr = row;
  assign o_col_addr = col;

  // register stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      div_cnt           <= 8'h00;
      o_pixel_clock_out <= 1'b0;
      state             <= ST_IDLE;
      row               <= 11'h000;
      col               <= 11'h000;
      pcnt              <= 17'h00000;
      vb_cnt            <= 16'h0000;
      lead              <= 1'b0;
      live              <= 4'h0;
      live_hb           <= readout_pkg::HBLANK_RESET;
      live_vb           <= readout_pkg::VBLANK_RESET;
      live_integ        <= readout_pkg::INTEG_RESET;
      o_pix_data        <= 10'h000;
      o_pix_color       <= 2'h0;
      o_line_valid      <= 1'b0;
      o_frame_valid     <= 1'b0;
      black_level       <= 16'h0000;
      o_row_read_stb    <= 1'b0;
      o_row_reset_stb   <= 1'b0;
      o_row_reset_addr  <= 11'h000;
    end else begin
      div_cnt           <= next_div_cnt;
      o_pixel_clock_out <= next_pclk;
      state             <= next_state;
      row               <= next_row;
      col               <= next_col;
      pcnt              <= next_pcnt;
      vb_cnt            <= next_vb_cnt;
      lead              <= next_lead;
      live              <= next_live;
      live_hb           <= next_live_hb;
      live_vb           <= next_live_vb;
      live_integ        <= next_live_integ;
      o_pix_data        <= next_pix;
      o_pix_color       <= next_color;
      o_line_valid      <= next_lv;
      o_frame_valid     <= next_fv;
      black_level       <= next_black;
      o_row_read_stb    <= next_rd_stb;
      o_row_reset_stb   <= next_rst_stb;
      o_row_reset_addr  <= next_rst_addr;
    end
  end

endmodule
`default_nettype wire

/* include/readout_pkg.sv */
// Behaviour
// - master clock comes from a PLL fed by a 6 to 40 MHz reference clock
// - by default one pixel leaves on every pixel clock period
// - rows are reset, then read later; exposure is the reset-to-read gap
// - every pixel sample is a 10-bit unsigned value
// - control and status registers are 16 bits wide, reached by the host
// - pixel stream carries a line qualifier and a frame qualifier
// - Bayer colours: even rows green/red, odd rows blue/green
// - array spans 1688 columns by 1256 rows; counters cover it all
// - first 52 and last 4 columns, top and bottom 20 rows shielded
// - default window 1600 by 1200 starting at row 28, column 60
// - boundary option widens the window by 4 pixels on every side
// - mirrored axis shifts the window start by 1 to keep colour order
// - progressive row readout; first pixel read is array pixel (52,20)
// - programmable horizontal and vertical blanking; line qualifier only on image
// - with firmware off the host writes readout settings and they apply
// - while line qualifier is high, one pixel word per pixel clock
// - pixel clock output keeps toggling through all blanking
package readout_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int PIX_W  = 10;
  localparam int REG_W  = 16;
  localparam int ADDR_W = 8;
  localparam int POS_W  = 11;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam logic [10:0] ARRAY_COLS      = 11'h0698; // 1688
  localparam logic [10:0] ARRAY_ROWS      = 11'h04E8; // 1256
  localparam logic [10:0] BLACK_LEAD_COLS = 11'h0034; // 52
  localparam logic [10:0] BLACK_TAIL_COLS = 11'h0004; // 4
  localparam logic [10:0] BLACK_ROWS      = 11'h0014; // 20
  localparam logic [10:0] WIN_W           = 11'h0640; // 1600
  localparam logic [10:0] WIN_H           = 11'h04B0; // 1200
  localparam logic [10:0] WIN_ROW0        = 11'h001C; // 28
  localparam logic [10:0] WIN_COL0        = 11'h003C; // 60
  localparam logic [10:0] BORDER          = 11'h0004; // 4
  localparam logic [10:0] MIRROR_SHIFT    = 11'h0001; // 1
  localparam logic [10:0] SCAN_ROW0       = 11'h0014; // 20
  localparam logic [10:0] SCAN_COL0       = 11'h0034; // 52

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_HBLANK = 8'h01;
  localparam logic [7:0] REG_VBLANK = 8'h02;
  localparam logic [7:0] REG_INTEG  = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REFCNT = 8'h05;
  localparam logic [7:0] REG_ROWPOS = 8'h06;
  localparam logic [7:0] REG_BLACK  = 8'h07;

  localparam logic [15:0] CTRL_RESET   = 16'h0001;
  localparam logic [15:0] HBLANK_RESET = 16'h015C; // 348 pixels
  localparam logic [15:0] VBLANK_RESET = 16'h0020; // 32 rows
  localparam logic [15:0] INTEG_RESET  = 16'h0010; // 16 rows

  localparam int CTRL_RUN        = 0;
  localparam int CTRL_BOUNDARY   = 1;
  localparam int CTRL_MIRROR_COL = 2;
  localparam int CTRL_MIRROR_ROW = 3;
  localparam int ST_REF_OK       = 0;
  localparam int ST_FRAME        = 1;
  localparam int ST_LINE         = 2;

  // ****************************************************************
  // colour codes {row parity, column parity}
  // ****************************************************************
  localparam logic [1:0] COLOR_GREEN_R = 2'h0;
  localparam logic [1:0] COLOR_RED     = 2'h1;
  localparam logic [1:0] COLOR_BLUE    = 2'h2;
  localparam logic [1:0] COLOR_GREEN_B = 2'h3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_HZ      = 100_000_000;
  localparam int REF_MIN_HZ  = 6_000_000;
  localparam int REF_MAX_HZ  = 40_000_000;
  localparam int REF_AVG     = 8; // reference periods per measurement
  localparam int REF_CNT_MIN = (REF_AVG * SYS_HZ + REF_MAX_HZ - 1) / REF_MAX_HZ;
  localparam int REF_CNT_MAX = (REF_AVG * SYS_HZ) / REF_MIN_HZ;
  localparam int PIX_DIV     = 2; // system cycles per pixel clock
  localparam int BLACK_SCALE = 6; // fraction bits of the black level
  localparam int BLACK_SHIFT = 4; // averaging weight of the black level

endpackage

/* hw/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic i_clk_sys, // system clock
  input  wire logic i_nrst,    // synchronous reset, active low
  input  wire logic i_pin,     // asynchronous pin
  output logic      o_level,   // filtered level
  output logic      o_rise     // one-cycle pulse on a rising change
);

  logic [2:0] sync;
  logic [2:0] next_sync;
  logic       next_level;
  logic       next_rise;

  // ****************************************************************
  // three stages; a change counts once stages two and three agree
  // ****************************************************************
  always_comb begin
    next_sync  = {sync[1:0], i_pin};
    next_level = o_level;
    next_rise  = 1'b0;
    if (sync[1] == sync[2]) begin
      next_level = sync[2];
      next_rise  = sync[2] & ~o_level;
    end
  end

  // register stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      sync    <= 3'h0;
      o_level <= 1'b0;
      o_rise  <= 1'b0;
    end else begin
      sync    <= next_sync;
      o_level <= next_level;
      o_rise  <= next_rise;
    end
  end

endmodule
`default_nettype wire

/* bench/pixel_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pixel_array_model (
  input  wire logic [10:0] i_row_addr, // row being read
  input  wire logic [10:0] i_col_addr, // column being read
  output logic      [9:0]  o_pix_data, // sample of that pixel
  output logic             o_ref_clk   // reference clock, 6.25 MHz
);
  // ****
  // array contents and reference
  // ****
  // each sample is a fixed function of its address, so a wrong address shows
  assign o_pix_data = 10'(i_row_addr * 11'h0007 + i_col_addr);
  // reference just inside the accepted band, near its 6 MHz lower end
  initial o_ref_clk = 1'b0;
  always #80 o_ref_clk = ~o_ref_clk;
endmodule
`default_nettype wire

/* bench/sensor_readout_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_readout_assertions #(
  parameter int PIX_DIV = 2
) (
  input wire logic        i_clk_sys,         // clock
  input wire logic        i_nrst,            // reset
  input wire logic        i_rd_stb,          // read strobe
  input wire logic [15:0] o_rd_data,         // read data
  input wire logic [10:0] o_row_addr,        // row
  input wire logic [10:0] o_col_addr,        // column
  input wire logic        o_row_read_stb,    // row read
  input wire logic        o_row_reset_stb,   // row reset
  input wire logic        o_pixel_clock_out, // pixel clock
  input wire logic [9:0]  o_pix_data,        // pixel word
  input wire logic        o_line_valid,      // line qualifier
  input wire logic        o_frame_valid      // frame qualifier
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // ****
  // properties
  // ****
  property p_blank_zero; !o_line_valid |-> o_pix_data == 10'h000; endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("data in blanking");
  property p_lv_in_fv; o_line_valid |-> o_frame_valid; endproperty
  a_lv_in_fv: assert property (p_lv_in_fv) else $error("line outside frame");
  property p_fv_fall; $fell(o_frame_valid) |-> $fell(o_line_valid); endproperty
  a_fv_fall: assert property (p_fv_fall) else $error("frame end off line end");
  property p_pck_run; 1'b1 |-> ##[1:PIX_DIV] $changed(o_pixel_clock_out); endproperty
  a_pck_run: assert property (p_pck_run) else $error("pixel clock stopped");
  property p_edge;
    $changed(o_pix_data) || $changed(o_line_valid) |-> $fell(o_pixel_clock_out);
  endproperty
  a_edge: assert property (p_edge) else $error("output moved off period");
  property p_pair; o_row_read_stb == o_row_reset_stb; endproperty
  a_pair: assert property (p_pair) else $error("read and reset apart");
  property p_range; o_row_addr < 11'h04E8 && o_col_addr < 11'h0698; endproperty
  a_range: assert property (p_range) else $error("address out of array");
  property p_row_start; o_row_read_stb |-> !o_line_valid; endproperty
  a_row_start: assert property (p_row_start) else $error("row start in line");
  property p_rd_idle; !$past(i_rd_stb) |-> o_rd_data == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data stands");
  c_line: cover property ($rose(o_line_valid));
  c_row: cover property (o_row_read_stb);
  c_read: cover property (i_rd_stb ##1 o_rd_data != 16'h0000);
endmodule
bind sensor_readout sensor_readout_assertions #(.PIX_DIV(PIX_DIV)) sensor_readout_assertions_i (
  .i_clk_sys, .i_nrst, .i_rd_stb, .o_rd_data, .o_row_addr, .o_col_addr, .o_row_read_stb,
  .o_row_reset_stb, .o_pixel_clock_out, .o_pix_data, .o_line_valid, .o_frame_valid);
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PD = 2;
  logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_fw_active = 1'b0, i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0, i_ref_clk, o_row_read_stb, o_row_reset_stb, o_pixel_clock_out;
  logic o_line_valid, o_frame_valid, o_ref_ok;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wr_data = 16'h0000, o_rd_data;
  logic [9:0] i_pix_data, o_pix_data;
  logic [10:0] o_row_addr, o_col_addr, o_row_reset_addr;
  logic [1:0] o_pix_color;
  int miscompares = 0;
  int samples_checked = 0;
  // ****
  // design, array and clock
  // ****
  sensor_readout #(.PIX_DIV(PD)) sensor_readout_i (.i_clk_sys, .i_nrst, .i_ref_clk,
    .i_fw_active, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data, .i_pix_data,
    .o_row_addr, .o_col_addr, .o_row_read_stb, .o_row_reset_stb, .o_row_reset_addr,
    .o_pixel_clock_out, .o_pix_data, .o_pix_color, .o_line_valid, .o_frame_valid, .o_ref_ok);
  pixel_array_model pixel_array_model_i (.i_row_addr(o_row_addr), .i_col_addr(o_col_addr),
    .o_pix_data(i_pix_data), .o_ref_clk(i_ref_clk));
  always #5 i_clk_sys = ~i_clk_sys;
  // ****
  // tasks
  // ****
  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_clk_sys);
    i_wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_clk_sys);
    i_rd_stb <= 1'b0;
    #1 check(name, o_rd_data, exp);
  endtask
  // bounded wait: 1 row start, 2 line valid
  task automatic wait_hi(input int which);
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1 n++;
    end while ((which == 1 ? o_row_read_stb : o_line_valid) !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      miscompares++;
      end_sim();
    end
  endtask
  // reset, program, then follow the first image line pixel by pixel
  task automatic run_frame(input logic [15:0] ctrl, input logic [10:0] row0,
                           input logic [10:0] col0, input int width, input int step);
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    i_fw_active <= 1'b1;
    rd_chk("ctrl", readout_pkg::REG_CTRL, 16'h0001);
    rd_chk("vblank", readout_pkg::REG_VBLANK, 16'h0020);
    rd_chk("integ", readout_pkg::REG_INTEG, 16'h0010);
    rd_chk("unmapped", 8'h08, 16'h0000);
    reg_wr(readout_pkg::REG_HBLANK, 16'h003C);
    rd_chk("hblank_fw", readout_pkg::REG_HBLANK, 16'h015C);
    @(posedge i_clk_sys);
    i_fw_active <= 1'b0;
    reg_wr(readout_pkg::REG_HBLANK, 16'h003C);
    reg_wr(readout_pkg::REG_CTRL, ctrl);
    rd_chk("hblank", readout_pkg::REG_HBLANK, 16'h003C);
    wait_hi(1);
    check("ref_ok", 16'(o_ref_ok), 16'h0001);
    check("row_first", 16'(o_row_addr), 16'h0014);
    check("col_first", 16'(o_col_addr), 16'h0034);
    check("row_reset", 16'(o_row_reset_addr), 16'h0024);
    rd_chk("refcnt", readout_pkg::REG_REFCNT, 16'h0080);
    wait_hi(2);
    check("win_row", 16'(o_row_addr), 16'(row0));
    check("frame_valid", 16'(o_frame_valid), 16'h0001);
    for (int k = 0; k < width; k++) begin
      check("pix", 16'(o_pix_data), 16'(10'(row0 * 11'h0007 + col0 + 11'(k * step))));
      check("color", 16'(o_pix_color), 16'({row0[0], col0[0] ^ k[0]}));
      check("line_valid", 16'(o_line_valid), 16'h0001);
      repeat (PD) @(posedge i_clk_sys);
      #1;
    end
    check("line_end", 16'(o_line_valid), 16'h0000);
    check("blank_data", 16'(o_pix_data), 16'h0000);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    run_frame(16'h0001, 11'h001C, 11'h003C, 1600, 1);
    run_frame(16'h0003, 11'h0018, 11'h0038, 1608, 1);
    run_frame(16'h000D, 11'h04CC, 11'h067C, 1600, -1);
    end_sim();
  end
endmodule
`default_nettype wire
